// file: rtl/motor_trigger_conversion_program.sv
// Program table, APB register file and trigger front end of the ADC unit
// =====================================================================
// Overview of operation
// - Interrupt choice per program: 10 raises completion, 00/11 none.
// - Six setting registers, four slots each: enable, phase tag, channel.
// - Enabled slot converts its channel; result goes to result register m.
// - Channel codes 2 to 12 are inputs; all other codes are reserved.
// - Program number indexes both its setting and its interrupt choice.
// - Phase tag: 00 none, 01 U, 10 V, 11 W, passed to converter.
// - Trigger program number 0 to 5 valid; 6 and 7 reserved.
`timescale 1ns/10ps
module motor_trigger_conversion_program
    import mtcp_pkg::*;
#(
    parameter int RES_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic trig_valid_i,
    input wire logic [2:0] trigger_program_number_i,
    input wire logic conv_done_i,
    input wire logic [RES_W-1:0] conv_data_i,
    output logic conv_req_o,
    output logic [4:0] conv_channel_o,
    output logic [1:0] conv_phase_o,
    output logic [1:0] conv_slot_o,
    output logic conversion_done_irq_o,
    output logic irq_o
);
    // =================================================================
    // State
    typedef struct packed {
        logic [NUM_PROGS-1:0][31:0] set;
        logic [NUM_PROGS-1:0][1:0] ints;
        logic [NUM_SLOTS-1:0][RES_W-1:0] result;
        logic start;
        logic [31:0] prog_word;
        logic [1:0] irq_sel;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } regs_state_t;
    regs_state_t s, next_s;

    conv_if #(.RES_W(RES_W)) io();

    logic [EV_W-1:0] events;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic access;
    logic wr_now;
    logic hit;
    logic [31:0] rdata;
    logic [31:0] sel_word;

    assign access = psel_i && penable_i;
    // Writes land only on the edge that completes the access
    assign wr_now = access && s.pready && pwrite_i;
    assign sel_word = s.set[trigger_program_number_i];

    // =================================================================
    // Register decode and next state
    always_comb begin
        next_s = s;
        hit = 1'b0;
        rdata = 32'h0000_0000;
        next_s.start = 1'b0;
        for (int i = 0; i < NUM_PROGS; i++) begin
            if (paddr_i == OFS_SET0 + 12'(4 * i)) begin
                hit = 1'b1;
                rdata = s.set[i];
                if (wr_now) begin
                    next_s.set[i] = pwdata_i;
                end
            end
            if (paddr_i == OFS_INTS0 + 12'(4 * i)) begin
                hit = 1'b1;
                rdata = {30'h0, s.ints[i]};
                if (wr_now) begin
                    next_s.ints[i] = pwdata_i[1:0];
                end
            end
        end
        for (int m = 0; m < NUM_SLOTS; m++) begin
            if (paddr_i == OFS_RESULT0 + 12'(4 * m)) begin
                hit = 1'b1;
                rdata = 32'(s.result[m]);
            end
        end
        if (paddr_i == OFS_STATUS) begin
            hit = 1'b1;
            rdata = 32'(status);
        end
        if (paddr_i == OFS_MASK) begin
            hit = 1'b1;
            rdata = 32'(mask);
        end
        if (paddr_i == OFS_STATE) begin
            hit = 1'b1;
            rdata = {31'h0, io.busy};
        end
        // One wait state: pready rises the edge after the access starts
        next_s.pready = access && !s.pready;
        if (access && !s.pready) begin
            next_s.prdata = pwrite_i ? 32'h0000_0000 : rdata;
            next_s.pslverr = !hit;
        end
        // Trigger front end
        if (trig_valid_i && trigger_program_number_i <= PROG_LAST &&
            !io.busy && !s.start) begin
            next_s.start = 1'b1;
            next_s.prog_word = s.set[trigger_program_number_i];
            next_s.irq_sel = s.ints[trigger_program_number_i];
        end
        if (io.res_we) begin
            next_s.result[io.res_idx] = io.res_data;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{set: {NUM_PROGS{SET_RST}}, ints: {NUM_PROGS{INTS_RST}},
                   irq_sel: INTS_RST, default: '0};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // =================================================================
    // Events: reserved program numbers and busy triggers are dropped
    always_comb begin
        events = '0;
        events[EV_DONE] = io.done_irq;
        events[EV_BADPROG] = trig_valid_i &&
                             trigger_program_number_i > PROG_LAST;
        events[EV_BADCHAN] = io.bad_chan;
        events[EV_OVERRUN] = trig_valid_i &&
                             trigger_program_number_i <= PROG_LAST &&
                             (io.busy || s.start);
    end

    irq_ctrl u_irq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .events_i(events),
        .clear_we_i(wr_now && paddr_i == OFS_STATUS),
        .mask_we_i(wr_now && paddr_i == OFS_MASK),
        .wdata_i(pwdata_i[EV_W-1:0]),
        .status_o(status),
        .mask_o(mask),
        .irq_o(irq_o)
    );

    prog_seq #(.RES_W(RES_W)) u_seq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .io(io.seq),
        .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i),
        .conv_req_o(conv_req_o),
        .conv_channel_o(conv_channel_o),
        .conv_phase_o(conv_phase_o),
        .conv_slot_o(conv_slot_o)
    );

    assign io.start = s.start;
    assign io.prog_word = s.prog_word;
    assign io.irq_sel = s.irq_sel;
    assign prdata_o = s.prdata;
    assign pready_o = s.pready;
    assign pslverr_o = s.pslverr;
    assign conversion_done_irq_o = io.done_irq;

    // =================================================================
    // Checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_ready_one_wait: assert property (
        ce_i && access && !pready_o |=> pready_o)
        else $error("pready not raised after one wait state");

    a_setting_store: assert property (
        ce_i && wr_now && paddr_i == OFS_SET0 + 12'h008
        |=> s.set[2] == $past(pwdata_i))
        else $error("program setting write lost");

    a_result_slot: assert property (
        ce_i && io.res_we
        |=> s.result[$past(io.res_idx)] == $past(io.res_data))
        else $error("result not stored in its slot register");

    a_prog_select: assert property (
        ce_i && trig_valid_i && !io.busy && !s.start &&
        trigger_program_number_i <= PROG_LAST
        |=> s.start && s.prog_word == $past(sel_word))
        else $error("trigger did not load its own program");

    a_prog_reserved: assert property (
        trig_valid_i && trigger_program_number_i > PROG_LAST
        |=> !s.start ##1 !conv_req_o || $past(conv_req_o, 2))
        else $error("reserved program number started a run");

    a_ints_upper_zero: assert property (
        ce_i && access && !pready_o && !pwrite_i &&
        paddr_i == OFS_INTS0 + 12'h004
        |=> prdata_o[31:2] == 30'h0000_0000 && !pslverr_o)
        else $error("interrupt select upper bits not zero");

    // Pulse comes with the end of a run and only for choice 10
    a_irq_choice: assert property (
        $past(ce_i) && (conversion_done_irq_o || $fell(io.busy))
        |-> $fell(io.busy)
            && conversion_done_irq_o == (s.irq_sel == IRQ_SEL_DONE))
        else $error("completion interrupt without choice 10");

    a_irq_level: assert property (
        ##1 irq_o == |($past(status | events) & $past(mask)) || !$past(ce_i)
        || $past(wr_now))
        else $error("interrupt level disagrees with status and mask");
endmodule // motor_trigger_conversion_program

// file: rtl/mtcp_pkg.sv
// Constants, field layouts and helpers for the motor trigger conversion block
package mtcp_pkg;
    localparam int NUM_PROGS = 6;
    localparam int NUM_SLOTS = 4;
    localparam int SLOT_W = 8;
    localparam int EN_POS = 7;
    localparam int PHASE_LSB = 5;
    localparam int CHAN_LSB = 0;
    localparam int EV_W = 4;
    localparam int EV_DONE = 0;
    localparam int EV_BADPROG = 1;
    localparam int EV_BADCHAN = 2;
    localparam int EV_OVERRUN = 3;
    localparam logic [11:0] OFS_SET0 = 12'h000;
    localparam logic [11:0] OFS_INTS0 = 12'h018;
    localparam logic [11:0] OFS_STATUS = 12'h030;
    localparam logic [11:0] OFS_MASK = 12'h034;
    localparam logic [11:0] OFS_STATE = 12'h038;
    localparam logic [11:0] OFS_RESULT0 = 12'h040;
    localparam logic [31:0] SET_RST = 32'h0000_0000;
    localparam logic [1:0] INTS_RST = 2'h0;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    localparam logic [1:0] IRQ_SEL_NONE0 = 2'h0;
    localparam logic [1:0] IRQ_SEL_RSVD = 2'h1;
    localparam logic [1:0] IRQ_SEL_DONE = 2'h2;
    localparam logic [1:0] IRQ_SEL_NONE1 = 2'h3;
    localparam logic [4:0] CHAN_FIRST = 5'h02;
    localparam logic [4:0] CHAN_LAST = 5'h0c;
    localparam logic [2:0] PROG_LAST = 3'h5;

    typedef enum logic [1:0] {
        PHASE_NONE = 2'h0,
        PHASE_U = 2'h1,
        PHASE_V = 2'h2,
        PHASE_W = 2'h3
    } phase_t;

    typedef struct packed {
        logic en;
        phase_t phase;
        logic [4:0] chan;
    } slot_t;

    function automatic logic chan_ok(input logic [4:0] c);
        return (c >= CHAN_FIRST) && (c <= CHAN_LAST);
    endfunction

    function automatic logic irq_wanted(input logic [1:0] sel);
        return sel == IRQ_SEL_DONE;
    endfunction

    function automatic slot_t slot_of(input logic [31:0] w,
                                      input logic [1:0] m);
        return slot_t'(w[m*SLOT_W +: SLOT_W]);
    endfunction
endpackage

// file: rtl/conv_if.sv
// Link between the register file and the program sequencer
`timescale 1ns/10ps
interface conv_if #(parameter int RES_W = 12);
    logic start;
    logic [31:0] prog_word;
    logic [1:0] irq_sel;
    logic busy;
    logic done;
    logic done_irq;
    logic bad_chan;
    logic res_we;
    logic [1:0] res_idx;
    logic [RES_W-1:0] res_data;
    modport regs (output start, prog_word, irq_sel,
                  input busy, done, done_irq, bad_chan,
                  res_we, res_idx, res_data);
    modport seq (input start, prog_word, irq_sel,
                 output busy, done, done_irq, bad_chan,
                 res_we, res_idx, res_data);
endinterface

// file: rtl/irq_ctrl.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/10ps
module irq_ctrl
    import mtcp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [EV_W-1:0] events_i,
    input wire logic clear_we_i,
    input wire logic mask_we_i,
    input wire logic [EV_W-1:0] wdata_i,
    output logic [EV_W-1:0] status_o,
    output logic [EV_W-1:0] mask_o,
    output logic irq_o
);
    typedef struct packed {
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic irq;
    } irq_state_t;
    irq_state_t s, next_s;

    always_comb begin
        next_s = s;
        // A new event beats a clear in the same cycle
        if (clear_we_i) begin
            next_s.status = s.status & ~wdata_i;
        end
        next_s.status = next_s.status | events_i;
        if (mask_we_i) begin
            next_s.mask = wdata_i;
        end
        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{status: '0, mask: MASK_RST, irq: 1'b0};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign status_o = s.status;
    assign mask_o = s.mask;
    assign irq_o = s.irq;
endmodule // irq_ctrl

// file: rtl/prog_seq.sv
// Walks the four slots of one program and drives the converter core
`timescale 1ns/10ps
module prog_seq
    import mtcp_pkg::*;
#(
    parameter int RES_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    conv_if.seq io,
    input wire logic conv_done_i,
    input wire logic [RES_W-1:0] conv_data_i,
    output logic conv_req_o,
    output logic [4:0] conv_channel_o,
    output logic [1:0] conv_phase_o,
    output logic [1:0] conv_slot_o
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_CHECK = 4'h2,
        ST_WAIT = 4'h4,
        ST_FINISH = 4'h8
    } seq_st_t;

    typedef struct packed {
        seq_st_t st;
        logic [1:0] slot;
        logic [31:0] word;
        logic [1:0] isel;
        logic req;
        logic [4:0] chan;
        logic [1:0] phase;
        logic done;
        logic done_irq;
        logic bad_chan;
        logic res_we;
        logic [RES_W-1:0] res_data;
    } seq_state_t;
    seq_state_t s, next_s;
    slot_t cur;

    always_comb begin
        next_s = s;
        cur = slot_of(s.word, s.slot);
        next_s.done = 1'b0;
        next_s.done_irq = 1'b0;
        next_s.bad_chan = 1'b0;
        next_s.res_we = 1'b0;
        case (s.st)
            ST_IDLE: begin
                if (io.start) begin
                    next_s.word = io.prog_word;
                    next_s.isel = io.irq_sel;
                    next_s.slot = 2'h0;
                    next_s.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (cur.en && chan_ok(cur.chan)) begin
                    next_s.req = 1'b1;
                    next_s.chan = cur.chan;
                    next_s.phase = cur.phase;
                    next_s.st = ST_WAIT;
                end else begin
                    // Reserved channel codes are skipped, never converted
                    next_s.bad_chan = cur.en;
                    next_s.slot = s.slot + 2'h1;
                    next_s.st = (s.slot == 2'h3) ? ST_FINISH : ST_CHECK;
                end
            end
            ST_WAIT: begin
                if (conv_done_i) begin
                    next_s.req = 1'b0;
                    next_s.res_we = 1'b1;
                    next_s.res_data = conv_data_i;
                    next_s.slot = s.slot + 2'h1;
                    next_s.st = (s.slot == 2'h3) ? ST_FINISH : ST_CHECK;
                end
            end
            ST_FINISH: begin
                next_s.done = 1'b1;
                next_s.done_irq = irq_wanted(s.isel);
                next_s.st = ST_IDLE;
            end
            default: begin
                next_s.st = ST_IDLE;
                next_s.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '{st: ST_IDLE, isel: INTS_RST, phase: PHASE_NONE,
                   default: '0};
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign io.busy = (s.st != ST_IDLE);
    assign io.done = s.done;
    assign io.done_irq = s.done_irq;
    assign io.bad_chan = s.bad_chan;
    assign io.res_we = s.res_we;
    // Result lands in the slot just left, one behind the counter
    assign io.res_idx = s.slot - 2'h1;
    assign io.res_data = s.res_data;
    assign conv_req_o = s.req;
    assign conv_channel_o = s.chan;
    assign conv_phase_o = s.phase;
    assign conv_slot_o = s.slot;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    a_done_irq_sel: assert property (
        ce_i && s.st == ST_FINISH |=> done_irq_chk(s))
        else $error("completion interrupt disagrees with choice");
    a_req_channel: assert property (
        conv_req_o |-> chan_ok(conv_channel_o))
        else $error("reserved channel sent to converter");
    a_req_phase: assert property (
        $rose(conv_req_o) |-> conv_phase_o == $past(cur.phase)
                              && $past(cur.en))
        else $error("phase tag or enable not taken from slot");

    function automatic logic done_irq_chk(input seq_state_t v);
        return v.done_irq == (v.isel == IRQ_SEL_DONE);
    endfunction
endmodule // prog_seq

// file: verif/conv_core_model.sv
// Behavioural converter core that answers the block's conversion requests
`timescale 1ns/10ps
module conv_core_model #(
    parameter int RES_W = 12
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic conv_req_i,
    input wire logic [4:0] conv_channel_i,
    input wire logic [1:0] conv_phase_i,
    input wire logic [1:0] conv_slot_i,
    output logic conv_done_o,
    output logic [RES_W-1:0] conv_data_o
);
    int cnt;
    // Result packs slot, phase and channel so a misrouted value shows up
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 0;
            conv_done_o <= 1'h0;
            conv_data_o <= '0;
        end else if (conv_done_o) begin
            // Data is only valid with done; afterwards it must not linger
            conv_done_o <= 1'h0;
            conv_data_o <= ~conv_data_o;
        end else if (conv_req_i) begin
            if (cnt >= (slow_i ? 12 : 1)) begin
                cnt <= 0;
                conv_done_o <= 1'h1;
                conv_data_o <= RES_W'({1'h1, conv_slot_i, conv_phase_i,
                                       conv_channel_i, 2'h1});
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule // conv_core_model

// file: verif/motor_trigger_conversion_program_bench.sv
// Self-checking bench for the motor trigger conversion program block
`timescale 1ns/10ps
module motor_trigger_conversion_program_bench;
    import mtcp_pkg::*;
    logic core_clk_i = 1'h0;
    logic rst_i = 1'h1;
    logic ce = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, trig_valid = 1'h0, slow = 1'h0;
    logic [2:0] prog_num = 3'h0;
    logic conv_done, conv_req, done_irq, irq, req_q = 1'h0;
    logic [11:0] conv_data;
    logic [4:0] conv_ch;
    logic [1:0] conv_ph, conv_sl;
    logic [1:0] sel [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h0};
    int errors = 0;
    int total_checks = 0;
    int irq_pulses = 0;
    int req_starts = 0;

    motor_trigger_conversion_program #(.RES_W(12))
        motor_trigger_conversion_program_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr),
        .trig_valid_i(trig_valid), .trigger_program_number_i(prog_num),
        .conv_done_i(conv_done), .conv_data_i(conv_data),
        .conv_req_o(conv_req), .conv_channel_o(conv_ch),
        .conv_phase_o(conv_ph), .conv_slot_o(conv_sl),
        .conversion_done_irq_o(done_irq), .irq_o(irq));

    conv_core_model #(.RES_W(12)) conv_core_model_inst (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow),
        .conv_req_i(conv_req), .conv_channel_i(conv_ch),
        .conv_phase_i(conv_ph), .conv_slot_i(conv_sl),
        .conv_done_o(conv_done), .conv_data_o(conv_data));

    initial begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    always @(posedge core_clk_i) begin
        if (done_irq === 1'h1)
            irq_pulses++;
        if (conv_req === 1'h1 && req_q !== 1'h1)
            req_starts++;
        req_q = conv_req;
    end

    // =========================================================
    // Bus and check helpers
    task automatic check(input string nm, input logic [31:0] ex,
                         input logic [31:0] got);
        total_checks++;
        if (got !== ex) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Entered just after a rising edge; holds the request until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk_i);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50)
            errors++;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge core_clk_i);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'h1, a, wd, d, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex,
                          input string nm);
        logic [31:0] d;
        logic e;
        apb(1'h0, a, 32'h0, d, e);
        check(nm, ex, d);
    endtask

    task automatic trig(input logic [2:0] p);
        trig_valid <= 1'h1;
        prog_num <= p;
        @(posedge core_clk_i);
        trig_valid <= 1'h0;
        @(posedge core_clk_i);
    endtask

    task automatic wait_idle();
        logic [31:0] d;
        logic e;
        int n;
        n = 0;
        do begin
            apb(1'h0, OFS_STATE, 32'h0, d, e);
            n++;
        end while (d[0] !== 1'h0 && n < 200);
        if (n >= 200)
            errors++;
    endtask

    function automatic logic [31:0] res_val(input int m, input int ch);
        return {20'h0, 1'h1, 2'(m), 2'(m), 5'(ch), 2'h1};
    endfunction

    // Phase tag equals slot index, so all four tags get used
    function automatic logic [31:0] set_word(input int n);
        logic [31:0] w;
        for (int m = 0; m < 4; m++)
            w[8*m +: 8] = {1'(!(n == 5 && m == 1)), 2'(m), 5'(2 + n + m)};
        return w;
    endfunction

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk_i);
        errors++;
        final_report();
    end

    // =========================================================
    // Test sequence
    initial begin
        logic [31:0] d;
        logic e;
        int p0, r0;
        logic [31:0] exp_res [4];
        for (int m = 0; m < 4; m++)
            exp_res[m] = 32'h0;
        repeat (20) @(posedge core_clk_i);
        rst_i <= 1'h0;
        @(posedge core_clk_i);
        for (int n = 0; n < 6; n++) begin
            rd_chk(OFS_SET0 + 12'(4*n), SET_RST, "set_reset");
            rd_chk(OFS_INTS0 + 12'(4*n), 32'h0, "sel_reset");
        end
        for (int n = 0; n < 6; n++) begin
            wr(OFS_SET0 + 12'(4*n), set_word(n));
            wr(OFS_INTS0 + 12'(4*n), 32'hffff_fffc | 32'(sel[n]));
        end
        for (int n = 0; n < 6; n++) begin
            rd_chk(OFS_SET0 + 12'(4*n), set_word(n), "set_back");
            rd_chk(OFS_INTS0 + 12'(4*n), 32'(sel[n]), "sel_back");
        end
        $display("test registers done");
        for (int n = 0; n < 6; n++) begin
            p0 = irq_pulses;
            r0 = req_starts;
            trig(3'(n));
            wait_idle();
            for (int m = 0; m < 4; m++)
                if (!(n == 5 && m == 1))
                    exp_res[m] = res_val(m, 2 + n + m);
            rd_chk(OFS_STATUS, 32'(sel[n] == 2'h2), "status");
            check("done_pulse", 32'(sel[n] == 2'h2),
                  32'(irq_pulses - p0));
            check("conversions", (n == 5) ? 32'h3 : 32'h4,
                  32'(req_starts - r0));
            wr(OFS_STATUS, 32'hf);
            for (int m = 0; m < 4; m++)
                rd_chk(OFS_RESULT0 + 12'(4*m),
                       exp_res[m], "result");
        end
        $display("test program_runs done");
        r0 = req_starts;
        trig(3'h6);
        trig(3'h7);
        rd_chk(OFS_STATUS, 32'h2, "status_badprog");
        check("no_run", 32'h0, 32'(req_starts - r0));
        wr(OFS_MASK, 32'h2);
        repeat (2) @(posedge core_clk_i);
        check("irq_on", 32'h1, 32'(irq));
        wr(OFS_MASK, 32'h0);
        repeat (2) @(posedge core_clk_i);
        check("irq_off", 32'h0, 32'(irq));
        wr(OFS_STATUS, 32'h2);
        rd_chk(OFS_STATUS, 32'h0, "status_clear");
        $display("test reserved_program done");
        // Reserved codes either side of the legal range, and the top code
        wr(OFS_SET0, 32'hecdf_ad81);
        r0 = req_starts;
        trig(3'h0);
        wait_idle();
        check("chan_skip", 32'h1, 32'(req_starts - r0));
        rd_chk(OFS_STATUS, 32'h4, "status_badchan");
        rd_chk(OFS_RESULT0 + 12'hc, res_val(3, 12), "chan_top");
        wr(OFS_STATUS, 32'hf);
        $display("test reserved_channel done");
        slow <= 1'h1;
        r0 = req_starts;
        trig(3'h3);
        repeat (4) @(posedge core_clk_i);
        trig(3'h3);
        wait_idle();
        check("busy_runs", 32'h4, 32'(req_starts - r0));
        rd_chk(OFS_STATUS, 32'h8, "status_busy");
        slow <= 1'h0;
        wr(OFS_STATUS, 32'hf);
        $display("test busy_trigger done");
        // A trigger while the clock enable is low must leave no trace
        ce <= 1'h0;
        r0 = req_starts;
        trig(3'h0);
        ce <= 1'h1;
        repeat (4) @(posedge core_clk_i);
        check("ce_frozen", 32'h0, 32'(req_starts - r0));
        rd_chk(OFS_STATUS, 32'h0, "status_frozen");
        $display("test clock_enable done");
        apb(1'h0, 12'h03c, 32'h0, d, e);
        check("unmapped_err", 32'h1, 32'(e));
        check("unmapped_data", 32'h0, d);
        apb(1'h1, 12'h001, 32'hffff_ffff, d, e);
        check("misaligned_err", 32'h1, 32'(e));
        rd_chk(OFS_SET0, 32'hecdf_ad81, "set_kept");
        $display("test bad_address done");
        final_report();
    end
endmodule // motor_trigger_conversion_program_bench
